// ---- logic/ssa_pkg.sv ----
// Contract
// - Four comparator channels: three phase inputs plus one shared by four aux inputs via a 2-bit select.
// - The ramp capacitor is held in reset while the period sync pulse is high (default 40 cycles).
// - The ramp reset is released on the falling edge of the period sync pulse.
// - The 12-bit counter advances every second clock when the rate bit is 0, every clock when 1.
// - The counter is held cleared while the period sync pulse is high.
// - The first rising comparator output in each ramp captures the current count into that channel's master.
// - On each rising sync edge the masters of channels that captured are copied to their readable shadows.
// - Shadows hold the previous period's counts while masters collect the current ones.
// - A channel whose comparator never rises during the ramp reports 0xFFF0.
// - A count never exceeds 4095; the counter saturates there.
// - All four channels can convert within each sync period.
package ssa_pkg;
    // ************************************************************
    // constants
    // ************************************************************
    localparam int          SSA_CHANNELS  = 4;
    localparam int          SSA_CNT_W     = 12;
    localparam int          SSA_RES_W     = 16;
    localparam logic [11:0] SSA_CNT_MAX   = 12'hFFF;
    localparam logic [15:0] SSA_OVER_CODE = 16'hFFF0;
    localparam logic [15:0] SSA_RES_RST   = 16'h0000;
    localparam int          SSA_SYNC_CYC  = 40;
    localparam int          SSA_RATE_BIT  = 7;
    localparam int          SSA_MUX_LO    = 0;
    localparam int          SSA_MUX_HI    = 1;

    typedef struct packed {
        logic phase_input_one;
        logic phase_input_two;
        logic phase_input_three;
        logic [3:0] aux_input;
    } ssa_cmp_s;

    typedef struct packed {
        logic [15:0] result_channel_one;
        logic [15:0] result_channel_two;
        logic [15:0] result_channel_three;
        logic [15:0] result_shared_channel;
    } ssa_res_s;
endpackage

// ---- logic/ssa_core.sv ----
module ssa_core (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             period_sync_pulse,
    input  wire logic [15:0]      mode_control_word,
    input  wire ssa_pkg::ssa_cmp_s cmp_in,
    output logic                  ramp_reset,
    output ssa_pkg::ssa_res_s     results,
    output logic [11:0]           count_value
);
    import ssa_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {SSA_IDLE, SSA_HOLD, SSA_RAMP} ssa_state_e;

    ssa_state_e        state_reg,   state_next;
    logic [11:0]       cnt_reg,     cnt_next;
    logic              div_reg,     div_next;
    logic              sync_d_reg;
    logic [3:0]        s1_reg,      s2_reg,      s3_reg;
    logic [3:0]        done_reg,    done_next;
    logic [11:0]       mst_reg  [4];
    logic [11:0]       mst_next [4];
    logic [15:0]       shd_reg  [4];
    logic [15:0]       shd_next [4];
    logic [3:0]        cmp_raw;
    logic [3:0]        cmp_rise;
    logic              sync_rise;
    logic              sync_fall;
    logic              rate_fast;
    logic [1:0]        aux_sel;

    // ************************************************************
    // comparator front end
    // ************************************************************
    // aux select
    assign aux_sel   = {mode_control_word[SSA_MUX_HI], mode_control_word[SSA_MUX_LO]};
    assign rate_fast = mode_control_word[SSA_RATE_BIT];
    assign cmp_raw   = {cmp_in.aux_input[aux_sel], cmp_in.phase_input_three,
                        cmp_in.phase_input_two, cmp_in.phase_input_one};
    assign cmp_rise  = s2_reg & ~s3_reg;
    assign sync_rise = period_sync_pulse & ~sync_d_reg;
    assign sync_fall = ~period_sync_pulse & sync_d_reg;

    assign ramp_reset  = period_sync_pulse;
    assign count_value = cnt_reg;

    // next-state logic
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        div_next   = div_reg;
        done_next  = done_reg;
        for (int i = 0; i < SSA_CHANNELS; i++) begin
            mst_next[i] = mst_reg[i];
            shd_next[i] = shd_reg[i];
        end
        if (period_sync_pulse) begin
            cnt_next   = '0;
            div_next   = 1'b0;
            state_next = SSA_HOLD;
        end else begin
            case (state_reg)
                SSA_IDLE: state_next = SSA_IDLE;
                SSA_HOLD: begin
                    if (sync_fall) begin
                        state_next = SSA_RAMP;
                    end
                end
                SSA_RAMP: begin
                    div_next = ~div_reg;
                    if ((rate_fast || div_reg) && cnt_reg != SSA_CNT_MAX) begin
                        cnt_next = cnt_reg + 12'h001;
                    end
                    for (int i = 0; i < SSA_CHANNELS; i++) begin
                        if (cmp_rise[i] && !done_reg[i]) begin
                            mst_next[i]  = cnt_reg;
                            done_next[i] = 1'b1;
                        end
                    end
                end
                default: state_next = SSA_IDLE;
            endcase
        end
        if (sync_rise) begin
            for (int i = 0; i < SSA_CHANNELS; i++) begin
                shd_next[i] = done_reg[i] ? {mst_reg[i], 4'h0} : SSA_OVER_CODE;
            end
            done_next = '0;
        end
    end

    // registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg  <= SSA_IDLE;
            cnt_reg    <= '0;
            div_reg    <= 1'b0;
            done_reg   <= '0;
            sync_d_reg <= 1'b0;
            s1_reg     <= '0;
            s2_reg     <= '0;
            s3_reg     <= '0;
            for (int i = 0; i < SSA_CHANNELS; i++) begin
                mst_reg[i] <= '0;
                shd_reg[i] <= SSA_RES_RST;
            end
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            div_reg    <= div_next;
            done_reg   <= done_next;
            sync_d_reg <= period_sync_pulse;
            s1_reg     <= cmp_raw;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            for (int i = 0; i < SSA_CHANNELS; i++) begin
                mst_reg[i] <= mst_next[i];
                shd_reg[i] <= shd_next[i];
            end
        end
    end

    assign results = '{result_channel_one:    shd_reg[0],
                       result_channel_two:    shd_reg[1],
                       result_channel_three:  shd_reg[2],
                       result_shared_channel: shd_reg[3]};

    // ************************************************************
    // assertions
    // ************************************************************
    // counter held in sync
    a_cnt_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(period_sync_pulse) |-> cnt_reg == 12'h000)
        else $error("counter not cleared during sync");

    a_cnt_sat: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(cnt_reg) == SSA_CNT_MAX && !$past(period_sync_pulse) |-> cnt_reg == SSA_CNT_MAX)
        else $error("counter wrapped past 4095");

    a_fast_rate: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == SSA_RAMP && rate_fast && !period_sync_pulse && cnt_reg != SSA_CNT_MAX
        |=> cnt_reg == $past(cnt_reg) + 12'h001 || $past(period_sync_pulse))
        else $error("fast rate did not advance each clock");

    a_slow_rate: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == SSA_RAMP && !rate_fast && !div_reg && !period_sync_pulse
        |=> cnt_reg == $past(cnt_reg))
        else $error("slow rate advanced on even clock");

    a_ramp_reset: assert property (@(posedge mclk) disable iff (sys_rst)
        ramp_reset == period_sync_pulse)
        else $error("ramp reset not following sync");

    a_hold_sync: assert property (@(posedge mclk) disable iff (sys_rst)
        period_sync_pulse |=> state_reg == SSA_HOLD)
        else $error("ramp left reset while sync high");

    a_release: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == SSA_HOLD && sync_fall |=> state_reg == SSA_RAMP)
        else $error("ramp not started on sync fall");

    a_mux_route: assert property (@(posedge mclk) disable iff (sys_rst)
        !$past(sys_rst) |-> s1_reg[3] == $past(cmp_in.aux_input[aux_sel])
            && s1_reg[0] == $past(cmp_in.phase_input_one))
        else $error("comparator input routed wrong");

    a_capture_val: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == SSA_RAMP && !period_sync_pulse && cmp_rise[1] && !done_reg[1]
        |=> mst_reg[1] == $past(cnt_reg) && done_reg[1])
        else $error("master missed current count");

    a_sync_nocap: assert property (@(posedge mclk) disable iff (sys_rst)
        period_sync_pulse |=> mst_reg[3] == $past(mst_reg[3]))
        else $error("master written while sync high");

    a_once_ramp: assert property (@(posedge mclk) disable iff (sys_rst)
        done_reg[2] && !sync_rise |=> mst_reg[2] == $past(mst_reg[2]))
        else $error("master recaptured within ramp");

    a_shadow_copy: assert property (@(posedge mclk) disable iff (sys_rst)
        sync_rise && done_reg[0] |=> shd_reg[0] == {$past(mst_reg[0]), 4'h0})
        else $error("shadow not loaded from master");

    a_done_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        sync_rise |=> done_reg == 4'h0)
        else $error("capture flags not cleared on sync");

    a_shadow_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !sync_rise |=> shd_reg[0] == $past(shd_reg[0]) && shd_reg[3] == $past(shd_reg[3]))
        else $error("shadow changed within period");

    a_over_code: assert property (@(posedge mclk) disable iff (sys_rst)
        sync_rise && !done_reg[3] |=> shd_reg[3] == SSA_OVER_CODE)
        else $error("missing overvoltage code");

    a_low_nibble: assert property (@(posedge mclk) disable iff (sys_rst)
        shd_reg[1][3:0] == 4'h0)
        else $error("result low nibble not zero");

    // main scenario covers
    c_capture: cover property (@(posedge mclk) disable iff (sys_rst)
        cmp_rise[0] && state_reg == SSA_RAMP);
    c_over: cover property (@(posedge mclk) disable iff (sys_rst)
        sync_rise && !done_reg[3]);
    c_sat: cover property (@(posedge mclk) disable iff (sys_rst)
        cnt_reg == SSA_CNT_MAX);
    c_all4: cover property (@(posedge mclk) disable iff (sys_rst)
        sync_rise && done_reg == 4'hF);
    c_slow: cover property (@(posedge mclk) disable iff (sys_rst)
        state_reg == SSA_RAMP && !rate_fast && div_reg);
endmodule

// ---- dv/ssa_reader.sv ----
module ssa_reader (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              period_sync_pulse,
    input  wire ssa_pkg::ssa_res_s results,
    output ssa_pkg::ssa_res_s      rd,
    output logic                   rd_ok
);
    timeunit 1ns;
    timeprecision 100ps;
    import ssa_pkg::*;
    logic [4:0] sync_sh_reg;
    logic [7:0] sets_reg;
    // sync history and result pickup after each sync rise
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync_sh_reg <= 5'h00;
            sets_reg    <= 8'h00;
            rd          <= '0;
            rd_ok       <= 1'b0;
        end else begin
            sync_sh_reg <= {sync_sh_reg[3:0], period_sync_pulse};
            // one period old, first set dropped
            if (sync_sh_reg[3] && !sync_sh_reg[4]) begin
                rd       <= results;
                sets_reg <= sets_reg + 8'h01;
                rd_ok    <= (sets_reg != 8'h00);
            end
        end
    end
endmodule

// ---- dv/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ssa_pkg::*;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        sync = 1'b0;
    logic [15:0] mode = 16'h0000;
    ssa_cmp_s    cmp = '0;
    ssa_res_s    results;
    ssa_res_s    rd;
    logic        ramp_reset;
    logic        rd_ok;
    logic [11:0] count_value;
    int          error_cnt = 0;
    int          cmp_count = 0;
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    ssa_core ssa_core_i (.mclk(mclk), .sys_rst(sys_rst), .period_sync_pulse(sync),
        .mode_control_word(mode), .cmp_in(cmp), .ramp_reset(ramp_reset),
        .results(results), .count_value(count_value));
    ssa_reader ssa_reader_i (.mclk(mclk), .sys_rst(sys_rst), .period_sync_pulse(sync),
        .results(results), .rd(rd), .rd_ok(rd_ok));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one sync period; rise times count ramp cycles, 0 means never for t1 and t2
    task automatic period(input logic rate, input logic [1:0] sel, input int len,
                          input int t1, input int t2, input int ta, input int tu);
        sync = 1'b1;
        cmp  = '0;
        mode = {8'h00, rate, 5'h00, sel};
        tick(SSA_SYNC_CYC - 1);
        check({4'h0, count_value}, 16'h0000);
        check({15'h0, ramp_reset}, 16'h0001);
        tick(1);
        sync = 1'b0;
        for (int c = 1; c <= len; c++) begin
            tick(1);
            cmp.phase_input_one = (t1 != 0) && c >= t1 && !(c >= t1 + 2 && c < t1 + 6);
            cmp.phase_input_two = (t2 != 0) && c >= t2;
            cmp.aux_input       = (c >= tu) ? 4'hF : 4'h0;
            cmp.aux_input[sel]  = c >= ta;
            if (c == 5) check({15'h0, ramp_reset}, 16'h0000);
        end
        check(results.result_channel_one, rd.result_channel_one);
        sync = 1'b1;
        cmp  = '0;
        tick(6);
    endtask
    // judge the set picked up by the reader
    task automatic judge;
        check({15'h0, rd_ok}, 16'h0001);
        check(rd.result_channel_two - rd.result_channel_one, 16'h00A0);
        check(rd.result_shared_channel - rd.result_channel_one, 16'h0050);
        check(rd.result_channel_three, SSA_OVER_CODE);
        check(rd.result_channel_one & 16'h000F, 16'h0000);
    endtask
    // first period after reset, its first set dropped
    task automatic scn_first_set;
        sync = 1'b1;
        tick(6);
        check({15'h0, rd_ok}, 16'h0000);
        period(1'b1, 2'h0, 200, 20, 30, 25, 15);
        judge();
    endtask
    // sweep of all four aux inputs at full rate
    task automatic scn_mux_sweep;
        for (int s = 0; s < 4; s++) begin
            period(1'b1, s[1:0], 200, 20, 30, 25, 15);
            judge();
        end
    endtask
    // half count rate
    task automatic scn_slow_rate;
        period(1'b0, 2'h0, 200, 20, 40, 30, 15);
        judge();
    endtask
    // long ramp, count stops at its top
    task automatic scn_saturate;
        period(1'b1, 2'h0, 4300, 4200, 30, 25, 15);
        check(rd.result_channel_one, SSA_OVER_CODE);
        check(rd.result_channel_three, SSA_OVER_CODE);
    endtask
    // main sequence
    initial begin
        tick(5);
        sys_rst = 1'b0;
        scn_first_set();
        scn_mux_sweep();
        scn_slow_rate();
        scn_saturate();
        final_report();
    end
endmodule
